// *** design/usdsp_pkg.sv ***
package usdsp_pkg;
    // ==========================================================
    // Operation codes
    localparam logic [7:0] USDSP_OP_UADD = 8'h43;  // 67
    localparam logic [7:0] USDSP_OP_USUB = 8'h45;  // 69
    localparam logic [7:0] USDSP_OP_QADD = 8'h4e;  // 78
    localparam logic [7:0] USDSP_OP_UMUL = 8'h8e;  // 142
    // ==========================================================
    // Latencies in core cycles
    localparam int USDSP_ALU_LAT = 2;
    localparam int USDSP_MUL_LAT = 3;
    // ==========================================================
    // Data layout and clip limits
    localparam int USDSP_WORD_W = 32;
    localparam int USDSP_LANE_W = 8;
    localparam int USDSP_LANES = 4;
    localparam logic [31:0] USDSP_WORD_MAX = 32'hffffffff;
    localparam logic [7:0] USDSP_BYTE_MAX = 8'hff;
    localparam logic [31:0] USDSP_ZERO = 32'h00000000;
    // ==========================================================
    // Issue slots, one-hot, slot 1 in bit 0
    localparam logic [3:0] USDSP_ALU_SLOTS = 4'h5;  // slots 1 and 3
    localparam logic [3:0] USDSP_MUL_SLOTS = 4'h6;  // slots 2 and 3
endpackage : usdsp_pkg

// *** design/usdsp_alu.sv ***
module usdsp_alu
    import usdsp_pkg::*;
#(
    parameter int WORD_W = USDSP_WORD_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic issue_valid_in,
    input wire logic [1:0] issue_slot_in,
    input wire logic [7:0] opcode_in,
    input wire logic [WORD_W-1:0] first_source_in,
    input wire logic [WORD_W-1:0] second_source_in,
    input wire logic guard_in,
    output logic alu_wr_en_out,
    output logic [WORD_W-1:0] alu_result_out,
    output logic mul_wr_en_out,
    output logic [WORD_W-1:0] mul_result_out
);

    // ==========================================================
    // Decode and slot check
    logic [3:0] slot_onehot;
    logic is_uadd;
    logic is_usub;
    logic is_qadd;
    logic is_umul;
    logic alu_take;
    logic mul_take;

    assign slot_onehot = 4'h1 << issue_slot_in;
    assign is_uadd = (opcode_in == USDSP_OP_UADD);
    assign is_usub = (opcode_in == USDSP_OP_USUB);
    assign is_qadd = (opcode_in == USDSP_OP_QADD);
    assign is_umul = (opcode_in == USDSP_OP_UMUL);
    // slot filtering; a misrouted op is dropped rather than trusted
    assign alu_take = issue_valid_in && (is_uadd || is_usub || is_qadd)
                      && |(slot_onehot & USDSP_ALU_SLOTS);
    assign mul_take = issue_valid_in && is_umul && |(slot_onehot & USDSP_MUL_SLOTS);

    // ==========================================================
    // ALU arithmetic, first stage
    logic [WORD_W:0] add_wide;
    logic [WORD_W:0] sub_wide;
    logic [WORD_W-1:0] add_clip;
    logic [WORD_W-1:0] sub_clip;
    logic [WORD_W-1:0] quad_clip;
    logic [WORD_W-1:0] alu_value;

    assign add_wide = {1'b0, first_source_in} + {1'b0, second_source_in};
    assign add_clip = add_wide[WORD_W] ? USDSP_WORD_MAX : add_wide[WORD_W-1:0];
    assign sub_wide = {1'b0, first_source_in} - {1'b0, second_source_in};
    assign sub_clip = sub_wide[WORD_W] ? USDSP_ZERO : sub_wide[WORD_W-1:0];

    for (genvar lane = 0; lane < USDSP_LANES; lane++) begin : g_lane
        logic signed [USDSP_LANE_W+1:0] lane_sum;
        // unsigned plus signed, ten bits holds every sum
        assign lane_sum = $signed({2'b00, first_source_in[lane*USDSP_LANE_W +: USDSP_LANE_W]})
            + $signed({{2{second_source_in[lane*USDSP_LANE_W+USDSP_LANE_W-1]}},
                       second_source_in[lane*USDSP_LANE_W +: USDSP_LANE_W]});
        assign quad_clip[lane*USDSP_LANE_W +: USDSP_LANE_W] =
            lane_sum[USDSP_LANE_W+1] ? USDSP_ZERO[USDSP_LANE_W-1:0] :
            lane_sum[USDSP_LANE_W] ? USDSP_BYTE_MAX : lane_sum[USDSP_LANE_W-1:0];
    end

    assign alu_value = is_uadd ? add_clip : (is_usub ? sub_clip : quad_clip);

    // ==========================================================
    // ALU pipeline, two stages
    logic alu_en_ff;
    logic [WORD_W-1:0] alu_val_ff;
    logic alu_wr_ff;
    logic [WORD_W-1:0] alu_res_ff;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            alu_en_ff <= 1'b0;
            alu_wr_ff <= 1'b0;
        end else begin
            alu_en_ff <= alu_take && guard_in;
            alu_wr_ff <= alu_en_ff;
        end
    end

    // data path, new op every cycle
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            alu_val_ff <= USDSP_ZERO;
            alu_res_ff <= USDSP_ZERO;
        end else begin
            alu_val_ff <= alu_value;
            alu_res_ff <= alu_val_ff;
        end
    end

    assign alu_wr_en_out = alu_wr_ff;
    assign alu_result_out = alu_res_ff;

    // ==========================================================
    // Multiplier pipeline, three stages; product registered once for timing
    logic [2*WORD_W-1:0] prod_ff;
    logic [WORD_W-1:0] mul_clip;
    logic [WORD_W-1:0] mul_c_ff;
    logic [WORD_W-1:0] mul_res_ff;
    logic [USDSP_MUL_LAT-1:0] mul_en_ff;

    // full product, clipped in stage two
    assign mul_clip = |prod_ff[2*WORD_W-1:WORD_W] ? USDSP_WORD_MAX : prod_ff[WORD_W-1:0];

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            prod_ff <= '0;
            mul_c_ff <= USDSP_ZERO;
            mul_res_ff <= USDSP_ZERO;
        end else begin
            prod_ff <= {{WORD_W{1'b0}}, first_source_in} * {{WORD_W{1'b0}}, second_source_in};
            mul_c_ff <= mul_clip;
            mul_res_ff <= mul_c_ff;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            mul_en_ff <= '0;
        end else begin
            mul_en_ff <= {mul_en_ff[USDSP_MUL_LAT-2:0], mul_take && guard_in};
        end
    end

    assign mul_wr_en_out = mul_en_ff[USDSP_MUL_LAT-1];
    assign mul_result_out = mul_res_ff;

    // ==========================================================
    // Checks
    // add timing
    uadd_latency_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (issue_valid_in && is_uadd && guard_in && issue_slot_in == 2'h0)
        |-> ##2 (alu_wr_en_out && alu_result_out == $past(add_clip, 2)))
        else $error("add result not written two cycles after issue");
    uadd_clip_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in && is_uadd && add_wide[WORD_W])
        |-> ##2 (alu_result_out == USDSP_WORD_MAX))
        else $error("add overflow not clipped to all ones");
    usub_floor_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in && is_usub && first_source_in < second_source_in)
        |-> ##2 (alu_wr_en_out && alu_result_out == USDSP_ZERO))
        else $error("negative difference not clipped to zero");
    usub_value_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in && is_usub && first_source_in >= second_source_in)
        |-> ##2 (alu_result_out == $past(first_source_in, 2) - $past(second_source_in, 2)))
        else $error("non-negative difference not passed through");
    usub_slot_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (issue_valid_in && is_usub && guard_in && issue_slot_in == 2'h2) |-> ##2 alu_wr_en_out)
        else $error("subtract in slot 3 not written");
    // byte add slot refusal, seen at the first pipeline stage
    qadd_slot_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (issue_valid_in && is_qadd && issue_slot_in == 2'h1) |=> !alu_en_ff)
        else $error("byte add accepted in slot 2");
    qadd_lane_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in && is_qadd && first_source_in[7:0] == 8'hff
         && second_source_in[7:0] == 8'h01) |-> ##2 (alu_result_out[7:0] == USDSP_BYTE_MAX))
        else $error("byte lane overflow not clipped");
    qadd_sign_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in && is_qadd && first_source_in[31:24] == 8'h01
         && second_source_in[31:24] == 8'hff) |-> ##2 (alu_result_out[31:24] == 8'h00))
        else $error("signed byte not treated as minus one");
    // adding zero keeps every byte in its own lane
    qadd_order_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in && is_qadd && second_source_in == USDSP_ZERO)
        |-> ##2 (alu_result_out == $past(first_source_in, 2)))
        else $error("byte lanes moved or mixed");
    guard_block_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!guard_in) |-> ##2 !alu_wr_en_out ##1 !mul_wr_en_out)
        else $error("write enable raised with guard low");
    umul_latency_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (mul_take && guard_in) |-> ##3 mul_wr_en_out)
        else $error("multiply result not written three cycles after issue");
    umul_slot_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (issue_valid_in && is_umul && (issue_slot_in == 2'h0 || issue_slot_in == 2'h3))
        |=> !mul_en_ff[0])
        else $error("multiply accepted in slot 1 or 4");
    umul_clip_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (mul_take && guard_in && first_source_in == 32'h80000000 && second_source_in == 32'h2)
        |-> ##3 (mul_result_out == USDSP_WORD_MAX))
        else $error("multiply overflow not clipped");
    alu_pipe_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (alu_take && guard_in) ##1 (alu_take && guard_in) |-> ##1 alu_wr_en_out ##1 alu_wr_en_out)
        else $error("back to back ALU ops not both written");
    mul_pipe_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (mul_take && guard_in) ##1 (mul_take && guard_in) |-> ##2 mul_wr_en_out ##1 mul_wr_en_out)
        else $error("back to back multiplies not both written");

endmodule : usdsp_alu

// *** test/usdsp_issuer.sv ***
module usdsp_issuer
    import usdsp_pkg::*;
(
    input wire logic [7:0] req_op_in,
    input wire logic alt_in,
    input wire logic bad_slot_in,
    output logic [1:0] slot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic is_mul;
    assign is_mul = (req_op_in == USDSP_OP_UMUL);
    // ==========================================================
    // Slot choice
    // permitted slots only
    // A forbidden slot is used only on command, to provoke a refusal
    always_comb begin
        if (bad_slot_in) begin
            slot_out = is_mul ? {alt_in, alt_in} : {alt_in, 1'b1};
        end else begin
            slot_out = is_mul ? {alt_in, ~alt_in} : {~alt_in, 1'b0};
        end
    end
endmodule : usdsp_issuer

// *** test/usdsp_alu_bench.sv ***
module usdsp_alu_bench
    import usdsp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic valid = 1'b0;
    logic guard = 1'b0;
    logic alt = 1'b0;
    logic bad = 1'b0;
    logic [1:0] slot;
    logic [7:0] op = 8'h00;
    logic [31:0] src_a = 32'h0;
    logic [31:0] src_b = 32'h0;
    logic alu_en, mul_en;
    logic [31:0] alu_res, mul_res;
    logic aen[3] = '{default: 1'b0};
    logic men[4] = '{default: 1'b0};
    logic [31:0] ares[3];
    logic [31:0] mres[4];
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] ops[5] = '{USDSP_OP_UADD, USDSP_OP_USUB, USDSP_OP_QADD, USDSP_OP_UMUL, 8'h44};
    usdsp_issuer issuer (.req_op_in(op), .alt_in(alt), .bad_slot_in(bad), .slot_out(slot));
    usdsp_alu DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .issue_valid_in(valid),
        .issue_slot_in(slot), .opcode_in(op), .first_source_in(src_a),
        .second_source_in(src_b), .guard_in(guard), .alu_wr_en_out(alu_en),
        .alu_result_out(alu_res), .mul_wr_en_out(mul_en), .mul_result_out(mul_res));
    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    // ==========================================================
    // Expected result of one operation
    function automatic logic [31:0] calc(input logic [7:0] o, input logic [31:0] a, b);
        logic [63:0] w;
        int s;
        calc = 32'h0;
        w = (o == USDSP_OP_UMUL) ? {32'h0, a} * {32'h0, b} : {32'h0, a} + {32'h0, b};
        if (o == USDSP_OP_UADD || o == USDSP_OP_UMUL) calc = |w[63:32] ? USDSP_WORD_MAX : w[31:0];
        if (o == USDSP_OP_USUB) calc = (a < b) ? USDSP_ZERO : a - b;
        for (int i = 0; i < 4 && o == USDSP_OP_QADD; i++) begin
            s = int'(a[8*i+:8]) + int'($signed(b[8*i+:8]));
            calc[8*i+:8] = (s < 0) ? 8'h00 : ((s > 255) ? USDSP_BYTE_MAX : s[7:0]);
        end
    endfunction : calc
    task automatic check_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check_bit
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word
    task automatic stop_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // One cycle: check what is due, then present the next issue
    task automatic step(input logic v, input logic [7:0] o, input logic [31:0] a, b,
                        input logic g, input logic al, input logic bd);
        logic ok;
        @(negedge ref_clk_in);
        for (int i = 3; i > 0; i--) begin
            men[i] = men[i-1];
            mres[i] = mres[i-1];
        end
        aen[2] = aen[1];
        ares[2] = ares[1];
        aen[1] = aen[0];
        ares[1] = ares[0];
        check_bit("alu_wr_en_out", aen[2], alu_en);
        check_bit("mul_wr_en_out", men[3], mul_en);
        if (aen[2]) check_word("alu_result_out", ares[2], alu_res);
        if (men[3]) check_word("mul_result_out", mres[3], mul_res);
        valid = v;
        op = o;
        src_a = a;
        src_b = b;
        guard = g;
        alt = al;
        bad = bd;
        ok = v && g && !bd && rst_n_in;
        aen[0] = ok && (o == USDSP_OP_UADD || o == USDSP_OP_USUB || o == USDSP_OP_QADD);
        men[0] = ok && (o == USDSP_OP_UMUL);
        ares[0] = calc(o, a, b);
        mres[0] = ares[0];
    endtask : step
    initial begin
        logic [31:0] r;
        r = $urandom(32'ha4a0d4cf);
        repeat (20) step(1'b0, 8'h00, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
        rst_n_in = 1'b1;
        step(1'b1, USDSP_OP_UADD, 32'hffffffff, 32'h00000001, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_UADD, 32'h80000001, 32'h7fffffff, 1'b1, 1'b1, 1'b0);
        step(1'b1, USDSP_OP_USUB, 32'h00000000, 32'h00000001, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_USUB, 32'h00001200, 32'h000000ff, 1'b1, 1'b1, 1'b0);
        step(1'b1, USDSP_OP_QADD, 32'h9c9c6464, 32'h649c649c, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_QADD, 32'h02010001, 32'hffffff01, 1'b1, 1'b1, 1'b0);
        step(1'b1, USDSP_OP_QADD, 32'h010000ff, 32'hff000001, 1'b1, 1'b1, 1'b0);
        step(1'b1, USDSP_OP_QADD, 32'h12345678, 32'h00000000, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_UMUL, 32'h80000000, 32'h00000002, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_UMUL, 32'h40000000, 32'h00000002, 1'b1, 1'b1, 1'b0);
        step(1'b1, USDSP_OP_UMUL, 32'hffffffff, 32'hffffffff, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_USUB, 32'h80000001, 32'hffffffff, 1'b1, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_UADD, 32'h00001200, 32'h000000ff, 1'b0, 1'b0, 1'b0);
        step(1'b1, USDSP_OP_UADD, 32'h00001200, 32'h000000ff, 1'b1, 1'b1, 1'b0);
        step(1'b1, USDSP_OP_UMUL, 32'h00000010, 32'h00000020, 1'b1, 1'b1, 1'b1);
        step(1'b1, USDSP_OP_QADD, 32'h00000010, 32'h00000020, 1'b1, 1'b0, 1'b1);
        step(1'b1, 8'h44, 32'h00000010, 32'h00000020, 1'b1, 1'b0, 1'b0);
        for (int n = 0; n < 3000; n++) begin
            r = $urandom();
            step(r[13] | r[14], ops[r[2:0] % 5], r[3] ? $urandom() : {32{r[4]}},
                 r[5] ? $urandom() : {32{r[6]}}, r[7] | r[8], r[9], r[10] & r[11]);
        end
        repeat (4) step(1'b0, 8'h00, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
        stop_test();
    end
endmodule : usdsp_alu_bench
